/* rtl/rse_pkg.sv */
// Constants, command codes and state layout for the rotate, skip and return execution unit.
// Assumes one core clock; the register offsets are byte addresses on an AXI4-Lite slave.
`default_nettype none
package rse_pkg;
    // Storage sizes.
    localparam int MEM_N = 16;
    localparam int STK_N = 8;
    localparam int PC_W  = 13;

    // Register byte offsets.
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_WORK  = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_PC    = 8'h0C;
    localparam logic [7:0] OFS_STACK = 8'h10;
    localparam logic [7:0] OFS_MSEL  = 8'h14;
    localparam logic [7:0] OFS_MDATA = 8'h18;
    localparam logic [7:0] OFS_STAT  = 8'h1C;

    // Command word field positions.
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 8;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_IMM_LSB  = 24;

    // Flag register bit positions.
    localparam int FLG_C   = 0;
    localparam int FLG_AC  = 1;
    localparam int FLG_Z   = 2;
    localparam int FLG_OV  = 3;
    localparam int FLG_GIE = 4;

    // Reset values and the set-byte pattern.
    localparam logic [7:0]      WORK_RST  = 8'h00;
    localparam logic [4:0]      FLAGS_RST = 5'h00;
    localparam logic [PC_W-1:0] PC_RST    = 13'h0000;
    localparam logic [7:0]      BYTE_ONES = 8'hFF;

    // Cycle counts of an instruction.
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_LONG  = 2'h2;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP, OP_SUBROUTINE_EXIT, OP_RETURN_LITERAL, OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORKING,
        OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING,
        OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_WORKING,
        OP_ROTATE_RIGHT_THRU_CY, OP_ROTATE_RIGHT_THRU_CY_TO_WORKING,
        OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM,
        OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_WORKING,
        OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_TO_WORKING,
        OP_SET_BYTE, OP_SET_BIT, OP_BIT_SET_SKIP
    } rse_op_t;

    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_DUMMY} rse_phase_t;

    typedef struct packed {
        rse_op_t    op;
        logic [2:0] bit_sel;
        logic [3:0] addr;
        logic [7:0] imm;
    } rse_cmd_t;

    typedef struct packed {
        rse_phase_t                  phase;
        rse_cmd_t                    cmd;
        logic [7:0]                  work;
        logic [4:0]                  flags;
        logic [PC_W-1:0]             pc;
        logic [STK_N-1:0][PC_W-1:0]  stack;
        logic [3:0]                  depth;
        logic [MEM_N-1:0][7:0]       mem;
        logic [3:0]                  msel;
        logic                        skipped;
        logic [1:0]                  cyc;
        logic [1:0]                  last_cyc;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } rse_state_t;
endpackage
`default_nettype wire

/* rtl/rse_exec.sv */
// Execution unit for returns, rotates, subtract with borrow, byte and bit set and skips.
// Assumes an AXI4-Lite master on the core clock and software that loads memory and stack.
`default_nettype none
module rse_exec
    import rse_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             busy,
    output logic             global_irq_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    rse_state_t q;
    rse_state_t d;
    rse_state_t rst_val;

    logic       wr_go;
    logic       rd_go;
    logic [7:0] opnd;
    logic       carry;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic       do_pop;
    logic       skip;
    logic [3:0] top;

    // Register writes are refused while an instruction runs, so software cannot race it.
    // Readies follow the enable, so no item is taken while the state is frozen.
    assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !q.bvalid
                           && q.phase == PH_IDLE;
    assign rd_go         = ce && s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign busy              = q.phase != PH_IDLE;
    assign global_irq_enable = q.flags[FLG_GIE];

    // Operand datapath shared by every instruction that reads the addressed byte.
    assign opnd  = q.mem[q.cmd.addr];
    assign carry = q.flags[FLG_C];
    assign diff  = {1'b0, q.work} + {1'b0, ~opnd} + {8'h00, carry};
    assign nib   = {1'b0, q.work[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, carry};
    assign dec_v = opnd - 8'h01;
    assign inc_v = opnd + 8'h01;
    assign top   = q.depth - 4'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset image of the whole state.
    always_comb begin
        rst_val          = '0;
        rst_val.phase    = PH_IDLE;
        rst_val.cmd.op   = OP_NOP;
        rst_val.work     = WORK_RST;
        rst_val.flags    = FLAGS_RST;
        rst_val.pc       = PC_RST;
        rst_val.bresp    = RESP_OKAY;
        rst_val.rresp    = RESP_OKAY;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: instruction sequencing, then the register bus.
    always_comb begin
        d      = q;
        do_pop = 1'b0;
        skip   = 1'b0;
        unique case (q.phase)
            PH_IDLE: begin
                // Only the register bus below moves state here.
            end
            PH_EXEC: begin
                d.cyc = CYC_PLAIN;
                unique case (q.cmd.op)
                    OP_SUBROUTINE_EXIT: begin
                        do_pop = 1'b1;
                    end
                    OP_RETURN_LITERAL: begin
                        do_pop = 1'b1;
                        d.work = q.cmd.imm;
                    end
                    OP_INTERRUPT_EXIT: begin
                        do_pop = 1'b1;
                        d.flags[FLG_GIE] = 1'b1;
                    end
                    OP_ROTATE_LEFT: begin
                        d.mem[q.cmd.addr] = {opnd[6:0], opnd[7]};
                    end
                    OP_ROTATE_LEFT_TO_WORKING: begin
                        d.work = {opnd[6:0], opnd[7]};
                    end
                    OP_ROTATE_LEFT_THRU_CARRY: begin
                        d.mem[q.cmd.addr] = {opnd[6:0], carry};
                        d.flags[FLG_C]    = opnd[7];
                    end
                    OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
                        d.work         = {opnd[6:0], carry};
                        d.flags[FLG_C] = opnd[7];
                    end
                    OP_ROTATE_RIGHT: begin
                        d.mem[q.cmd.addr] = {opnd[0], opnd[7:1]};
                    end
                    OP_ROTATE_RIGHT_TO_WORKING: begin
                        d.work = {opnd[0], opnd[7:1]};
                    end
                    OP_ROTATE_RIGHT_THRU_CY: begin
                        d.mem[q.cmd.addr] = {carry, opnd[7:1]};
                        d.flags[FLG_C]    = opnd[0];
                    end
                    OP_ROTATE_RIGHT_THRU_CY_TO_WORKING: begin
                        d.work         = {carry, opnd[7:1]};
                        d.flags[FLG_C] = opnd[0];
                    end
                    OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                        // Carry set means no borrow, as in an add of the inverted operand.
                        d.flags[FLG_C]  = diff[8];
                        d.flags[FLG_AC] = nib[4];
                        d.flags[FLG_Z]  = diff[7:0] == 8'h00;
                        d.flags[FLG_OV] = (q.work[7] != opnd[7]) && (diff[7] != q.work[7]);
                        if (q.cmd.op == OP_SUBTRACT_WITH_BORROW_TO_MEM) begin
                            d.mem[q.cmd.addr] = diff[7:0];
                        end else begin
                            d.work = diff[7:0];
                        end
                    end
                    OP_DECREMENT_SKIP_ZERO: begin
                        d.mem[q.cmd.addr] = dec_v;
                        skip = dec_v == 8'h00;
                    end
                    OP_DECREMENT_SKIP_ZERO_TO_WORKING: begin
                        d.work = dec_v;
                        skip   = dec_v == 8'h00;
                    end
                    OP_INCREMENT_SKIP_ZERO: begin
                        d.mem[q.cmd.addr] = inc_v;
                        skip = inc_v == 8'h00;
                    end
                    OP_INCREMENT_SKIP_ZERO_TO_WORKING: begin
                        d.work = inc_v;
                        skip   = inc_v == 8'h00;
                    end
                    OP_SET_BYTE: begin
                        d.mem[q.cmd.addr] = BYTE_ONES;
                    end
                    OP_SET_BIT: begin
                        d.mem[q.cmd.addr][q.cmd.bit_sel] = 1'b1;
                    end
                    OP_BIT_SET_SKIP: begin
                        skip = opnd[q.cmd.bit_sel];
                    end
                    default: begin
                    end
                endcase
                // An empty stack leaves the counter and depth alone on a pop.
                if (do_pop) begin
                    if (q.depth != 4'h0) begin
                        d.pc    = q.stack[top[2:0]];
                        d.depth = top;
                    end
                    d.phase = PH_DUMMY;
                end else begin
                    d.pc    = q.pc + 13'h0001;
                    d.phase = skip ? PH_DUMMY : PH_IDLE;
                end
                // Status for software: skip taken and cycle count.
                d.skipped = skip;
                if (!do_pop && !skip) begin
                    d.last_cyc = CYC_PLAIN;
                end
            end
            PH_DUMMY: begin
                // The prefetched word is dropped; a skip steps over it.
                if (q.skipped) begin
                    d.pc = q.pc + 13'h0001;
                end
                d.cyc      = CYC_LONG;
                d.last_cyc = CYC_LONG;
                d.phase    = PH_IDLE;
            end
            default: begin
                d.phase = PH_IDLE;
            end
        endcase

        // A response leaves once the master has taken it.
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Register writes; an all-zero strobe is answered but stores nothing.
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            if (s_axi_wstrb != 4'h0) begin
                unique case (s_axi_awaddr)
                    OFS_CMD: begin
                        d.cmd.op      = rse_op_t'(s_axi_wdata[CMD_OP_LSB +: 5]);
                        d.cmd.bit_sel = s_axi_wdata[CMD_BIT_LSB +: 3];
                        d.cmd.addr    = s_axi_wdata[CMD_ADDR_LSB +: 4];
                        d.cmd.imm     = s_axi_wdata[CMD_IMM_LSB +: 8];
                        d.phase       = PH_EXEC;
                        d.skipped     = 1'b0;
                    end
                    OFS_WORK:  d.work  = s_axi_wdata[7:0];
                    OFS_FLAGS: d.flags = s_axi_wdata[4:0];
                    OFS_PC:    d.pc    = s_axi_wdata[PC_W-1:0];
                    OFS_STACK: begin
                        // Pushes beyond the depth are dropped rather than wrapping.
                        if (q.depth < 4'(STK_N)) begin
                            d.stack[q.depth[2:0]] = s_axi_wdata[PC_W-1:0];
                            d.depth = q.depth + 4'h1;
                        end
                    end
                    OFS_MSEL:  d.msel = s_axi_wdata[3:0];
                    OFS_MDATA: d.mem[q.msel] = s_axi_wdata[7:0];
                    default:   d.bresp = RESP_SLVERR;
                endcase
            end
        end

        // Register reads sample the state of the current cycle.
        // Unmapped offsets answer with an error and read as zero.
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                OFS_CMD:   d.rdata = {q.cmd.imm, 4'h0, q.cmd.addr, 5'h00, q.cmd.bit_sel,
                                      3'h0, q.cmd.op};
                OFS_WORK:  d.rdata[7:0] = q.work;
                OFS_FLAGS: d.rdata[4:0] = q.flags;
                OFS_PC:    d.rdata[PC_W-1:0] = q.pc;
                OFS_STACK: d.rdata[3:0] = q.depth;
                OFS_MSEL:  d.rdata[3:0] = q.msel;
                OFS_MDATA: d.rdata[7:0] = q.mem[q.msel];
                OFS_STAT:  d.rdata[4:0] = {q.last_cyc, q.skipped, q.phase};
                default:   d.rresp = RESP_SLVERR;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; the clock enable freezes everything, bus included.
    // Reset wins over the enable, so a frozen unit can still be cleared.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= rst_val;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

/* testbench/rse_exec_asserts.sv */
// Concurrent checks on the execution unit's bus handshake and instruction timing.
// Assumes it is bound to rse_exec and sees only that module's ports.
`default_nettype none
module rse_exec_asserts
    import rse_pkg::*;
(
    input wire logic        aclk, aresetn, ce, busy, global_irq_enable,
    input wire logic [7:0]  s_axi_awaddr, s_axi_araddr,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_take_q;

    // A register write is the only path besides an instruction that may raise the enable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_take_q <= 1'b0;
        end else begin
            wr_take_q <= s_axi_awvalid && s_axi_wvalid && s_axi_awready && ce;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////////////
    property p_wr_answer;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready && ce |=> s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read response late");
    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("write response dropped");
    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_no_write_busy;
        busy || s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_no_write_busy: assert property (p_no_write_busy) else $error("write taken while busy");
    property p_cmd_start;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready && ce && s_axi_awaddr == OFS_CMD
            && s_axi_wstrb != 4'h0 |=> busy;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command did not start");
    property p_busy_len;
        busy && ce ##1 busy && ce |=> !busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("instruction over two cycles");
    property p_irq_rise;
        $rose(global_irq_enable) |-> $past(busy) || wr_take_q;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("enable rose without cause");
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the rotate, skip and return execution unit.
// Assumes rse_pkg, rse_exec and the checker are compiled first; drives AXI4-Lite directly.
`default_nettype none
module testbench
    import rse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, busy, global_irq_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, dat, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          mismatches = 0, checks = 0, cycles = 0;
    logic [31:0] seed = 32'h0000F214;
    logic [7:0]  mem_m [MEM_N];
    logic [7:0]  work_m;
    logic        lag = 1'b0;
    logic [4:0]  flg_m;
    logic [PC_W-1:0] pc_m, stk_m [$];

    rse_exec rse_exec_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy),
        .global_irq_enable(global_irq_enable));

    // Free-running core clock, 20 ns period.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // A hang is cut short well above the few thousand cycles the tests need.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data are offered together and held until the slave takes them.
    // With lag set, the ready for the answer rises a cycle after the answer stands.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= !lag;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        if (lag) @(posedge aclk);
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= !lag;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        if (lag) @(posedge aclk);
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rsp);
        check({30'h0, rsp}, {30'h0, RESP_OKAY});
    endtask

    task automatic setm(input logic [3:0] a, input logic [7:0] d);
        put(OFS_MSEL, {28'h0, a});
        put(OFS_MDATA, {24'h0, d});
        mem_m[a] = d;
    endtask

    task automatic push(input logic [PC_W-1:0] d);
        put(OFS_STACK, {19'h0, d});
        if (stk_m.size() < STK_N) stk_m.push_back(d);
    endtask

    // Predict one instruction, run it, then compare status, work, flags, counter, the addressed byte, stack depth and enable.
    task automatic exec(input rse_op_t op, input logic [2:0] b, input logic [3:0] a,
                        input logic [7:0] im);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] m, x;
        logic       c, sk, rt;
        int         n, cy;
        m = mem_m[a];
        x = m;
        c = flg_m[0];
        sk = 1'b0;
        rt = 1'b0;
        case (op)
            OP_SUBROUTINE_EXIT, OP_RETURN_LITERAL, OP_INTERRUPT_EXIT: begin
                rt = 1'b1;
                if (stk_m.size() > 0) pc_m = stk_m.pop_back();
                if (op == OP_RETURN_LITERAL) work_m = im;
                if (op == OP_INTERRUPT_EXIT) flg_m[4] = 1'b1;
            end
            OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORKING: x = {m[6:0], m[7]};
            OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
                x = {m[6:0], c};
                flg_m[0] = m[7];
            end
            OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_WORKING: x = {m[0], m[7:1]};
            OP_ROTATE_RIGHT_THRU_CY, OP_ROTATE_RIGHT_THRU_CY_TO_WORKING: begin
                x = {c, m[7:1]};
                flg_m[0] = m[0];
            end
            OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                s = {1'b0, work_m} + {1'b0, ~m} + {8'h00, c};
                h = {1'b0, work_m[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
                x = s[7:0];
                flg_m[3:0] = {(work_m[7] ^ m[7]) & (x[7] ^ work_m[7]), x == 8'h00, h[4], s[8]};
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_WORKING: x = m - 8'h01;
            OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_TO_WORKING: x = m + 8'h01;
            OP_SET_BYTE: x = 8'hFF;
            OP_SET_BIT: x[b] = 1'b1;
            OP_BIT_SET_SKIP: sk = m[b];
            default: ;
        endcase
        if (op >= OP_DECREMENT_SKIP_ZERO && op <= OP_INCREMENT_SKIP_ZERO_TO_WORKING) sk = x == 8'h00;
        if (op inside {OP_ROTATE_LEFT_TO_WORKING, OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING,
                       OP_ROTATE_RIGHT_TO_WORKING, OP_ROTATE_RIGHT_THRU_CY_TO_WORKING,
                       OP_SUBTRACT_WITH_BORROW, OP_DECREMENT_SKIP_ZERO_TO_WORKING,
                       OP_INCREMENT_SKIP_ZERO_TO_WORKING}) work_m = x;
        else mem_m[a] = x;
        cy = (rt || sk) ? 2 : 1;
        if (!rt) pc_m = pc_m + (sk ? 13'h0002 : 13'h0001);
        lag = 1'b0;
        put(OFS_CMD, {im, 4'h0, a, 5'h0, b, 3'h0, op});
        n = 0;
        while (busy === 1'b1 && n < 8) begin
            n++;
            @(posedge aclk);
        end
        check(n, cy);
        lag = im[0];
        rd(OFS_STAT, dat, rsp);
        check(dat, {27'h0, 2'(cy), sk, 2'h0});
        rd(OFS_WORK, dat, rsp);
        check(dat, {24'h0, work_m});
        rd(OFS_FLAGS, dat, rsp);
        check(dat, {27'h0, flg_m});
        rd(OFS_PC, dat, rsp);
        check(dat, {19'h0, pc_m});
        put(OFS_MSEL, {28'h0, a});
        rd(OFS_MDATA, dat, rsp);
        check(dat, {24'h0, mem_m[a]});
        rd(OFS_STACK, dat, rsp);
        check(dat, 32'(stk_m.size()));
        check({31'h0, global_irq_enable}, {31'h0, flg_m[4]});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, decode, every opcode, skip corners, then random traffic.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (mem_m[k]) mem_m[k] = 8'h00;
        {work_m, flg_m, pc_m} = '0;
        for (int k = 0; k < 4; k++) begin
            rd(OFS_WORK + 8'(4 * k), dat, rsp);
            check(dat, 32'h0);
        end
        rd(8'h20, dat, rsp);
        check({dat[31:2], rsp}, {30'h0, RESP_SLVERR});
        wr(8'h24, 32'h0, rsp);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        $display("test reset and decode done");
        for (int k = 0; k < MEM_N; k++) begin
            v = rnd();
            setm(k[3:0], v[7:0]);
        end
        put(OFS_WORK, {24'h0, v[15:8]});
        work_m = v[15:8];
        put(OFS_FLAGS, {28'h0, v[19:16]});
        flg_m = {1'b0, v[19:16]};
        for (int k = 0; k < 3; k++) push(13'(rnd()));
        for (int k = 0; k < 21; k++) exec(rse_op_t'(k), k[2:0], k[3:0], 8'(rnd()));
        exec(OP_SUBROUTINE_EXIT, 3'h0, 4'h0, 8'h00);
        setm(4'h5, 8'hFF);
        exec(OP_INCREMENT_SKIP_ZERO_TO_WORKING, 3'h0, 4'h5, 8'h00);
        exec(OP_INCREMENT_SKIP_ZERO, 3'h0, 4'h5, 8'h00);
        exec(OP_DECREMENT_SKIP_ZERO_TO_WORKING, 3'h0, 4'h5, 8'h00);
        setm(4'h5, 8'h01);
        exec(OP_DECREMENT_SKIP_ZERO_TO_WORKING, 3'h0, 4'h5, 8'h00);
        exec(OP_DECREMENT_SKIP_ZERO, 3'h0, 4'h5, 8'h00);
        exec(OP_BIT_SET_SKIP, 3'h7, 4'h5, 8'h00);
        exec(OP_SET_BIT, 3'h7, 4'h5, 8'h00);
        exec(OP_BIT_SET_SKIP, 3'h7, 4'h5, 8'h00);
        $display("test directed done");
        for (int k = 0; k < 120; k++) begin
            v = rnd();
            if (v[9:8] == 2'h0) setm(v[3:0], v[10] ? 8'hFF : 8'h01);
            if (v[12:11] == 2'h0) push(v[26:14]);
            if (v[18:16] == 3'h0) begin
                put(OFS_FLAGS, {28'h0, v[23:20]});
                flg_m = {1'b0, v[23:20]};
            end
            if (v[15:13] == 3'h0) begin
                @(posedge aclk);
                ce <= 1'b0;
                repeat (3) @(posedge aclk);
                ce <= 1'b1;
            end
            exec(rse_op_t'(v[31:27] % 5'd21), v[6:4], v[3:0], v[26:19]);
        end
        $display("test random done");
        finish_test();
    end
endmodule

bind rse_exec rse_exec_asserts rse_exec_asserts_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .busy(busy), .global_irq_enable(global_irq_enable), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_wdata(s_axi_wdata),
    .s_axi_rdata(s_axi_rdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp),
    .s_axi_rresp(s_axi_rresp));
`default_nettype wire
